// ==== logic/psalu_core.sv ====
// packed simd integer alu datapath, one registered result per request
`timescale 1ns/1ps
`default_nettype none
module psalu_core #(
  parameter int VEC_W = psalu_pkg::VEC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire psalu_pkg::psalu_req_t req,
  output logic rsp_valid,
  output psalu_pkg::psalu_rsp_t rsp
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic valid;
    psalu_pkg::psalu_rsp_t rsp;
  } psalu_state_t;

  psalu_state_t state;
  psalu_state_t next_state;
  logic [VEC_W-1:0] a;
  logic [VEC_W-1:0] b;
  logic [VEC_W-1:0] res;
  logic [15:0] msad [8];

  assign a = req.dst_val;
  assign b = req.src_val;

  // ****************************************
  // multi sad: block of four source bytes against sliding dst windows
  // ****************************************
  for (genvar g = 0; g < 8; g++) begin : g_msad
    psalu_sad4 u_sad (
      .a(a[8*g +: 32]),
      .b(b[31:0]),
      .sum(msad[g])
    );
  end

  // ****************************************
  // datapath
  // ****************************************
  always_comb begin
    logic [16:0] s17;
    logic [8:0] s9;
    logic [31:0] p32;
    logic [31:0] q32;
    logic [63:0] p64;
    logic [15:0] sad;
    logic [7:0] d8;
    logic [255:0] sh;
    res = '0;
    s17 = '0;
    s9 = '0;
    p32 = '0;
    q32 = '0;
    p64 = '0;
    sad = '0;
    d8 = '0;
    sh = '0;
    unique case (req.op)
      psalu_pkg::OP_SIGNED_WORD_MAX, psalu_pkg::OP_SIGNED_WORD_MIN: begin
        for (int i = 0; i < 8; i++) begin
          if (($signed(a[16*i +: 16]) > $signed(b[16*i +: 16]))
              == (req.op == psalu_pkg::OP_SIGNED_WORD_MAX)) begin
            res[16*i +: 16] = a[16*i +: 16];
          end else begin
            res[16*i +: 16] = b[16*i +: 16];
          end
        end
      end
      psalu_pkg::OP_UNSIGNED_BYTE_MAX, psalu_pkg::OP_UNSIGNED_BYTE_MIN: begin
        for (int i = 0; i < 16; i++) begin
          if ((a[8*i +: 8] > b[8*i +: 8]) == (req.op == psalu_pkg::OP_UNSIGNED_BYTE_MAX)) begin
            res[8*i +: 8] = a[8*i +: 8];
          end else begin
            res[8*i +: 8] = b[8*i +: 8];
          end
        end
      end
      psalu_pkg::OP_SIGNED_BYTE_MAX, psalu_pkg::OP_SIGNED_BYTE_MIN: begin
        for (int i = 0; i < 16; i++) begin
          if (($signed(a[8*i +: 8]) > $signed(b[8*i +: 8]))
              == (req.op == psalu_pkg::OP_SIGNED_BYTE_MAX)) begin
            res[8*i +: 8] = a[8*i +: 8];
          end else begin
            res[8*i +: 8] = b[8*i +: 8];
          end
        end
      end
      psalu_pkg::OP_UNSIGNED_WORD_MAX, psalu_pkg::OP_UNSIGNED_WORD_MIN: begin
        for (int i = 0; i < 8; i++) begin
          if ((a[16*i +: 16] > b[16*i +: 16]) == (req.op == psalu_pkg::OP_UNSIGNED_WORD_MAX)) begin
            res[16*i +: 16] = a[16*i +: 16];
          end else begin
            res[16*i +: 16] = b[16*i +: 16];
          end
        end
      end
      psalu_pkg::OP_SIGNED_DWORD_MAX, psalu_pkg::OP_SIGNED_DWORD_MIN: begin
        for (int i = 0; i < 4; i++) begin
          if (($signed(a[32*i +: 32]) > $signed(b[32*i +: 32]))
              == (req.op == psalu_pkg::OP_SIGNED_DWORD_MAX)) begin
            res[32*i +: 32] = a[32*i +: 32];
          end else begin
            res[32*i +: 32] = b[32*i +: 32];
          end
        end
      end
      psalu_pkg::OP_UNSIGNED_DWORD_MAX, psalu_pkg::OP_UNSIGNED_DWORD_MIN: begin
        for (int i = 0; i < 4; i++) begin
          if ((a[32*i +: 32] > b[32*i +: 32]) == (req.op == psalu_pkg::OP_UNSIGNED_DWORD_MAX)) begin
            res[32*i +: 32] = a[32*i +: 32];
          end else begin
            res[32*i +: 32] = b[32*i +: 32];
          end
        end
      end
      psalu_pkg::OP_UNSIGNED_WORD_MUL_HIGH: begin
        for (int i = 0; i < 8; i++) begin
          p32 = a[16*i +: 16] * b[16*i +: 16];
          res[16*i +: 16] = p32[31:16];
        end
      end
      psalu_pkg::OP_SIGNED_WORD_MUL_HIGH: begin
        for (int i = 0; i < 8; i++) begin
          p32 = 32'($signed(a[16*i +: 16]) * $signed(b[16*i +: 16]));
          res[16*i +: 16] = p32[31:16];
        end
      end
      psalu_pkg::OP_WORD_MUL_LOW: begin
        for (int i = 0; i < 8; i++) begin
          p32 = 32'($signed(a[16*i +: 16]) * $signed(b[16*i +: 16]));
          res[16*i +: 16] = p32[15:0];
        end
      end
      psalu_pkg::OP_UNSIGNED_DWORD_WIDENING_MUL: begin
        for (int h = 0; h < 2; h++) begin
          p64 = a[64*h +: 32] * b[64*h +: 32];
          res[64*h +: 64] = p64;
        end
      end
      psalu_pkg::OP_DWORD_MUL_LOW: begin
        for (int i = 0; i < 4; i++) begin
          p64 = 64'($signed(a[32*i +: 32]) * $signed(b[32*i +: 32]));
          res[32*i +: 32] = p64[31:0];
        end
      end
      psalu_pkg::OP_SIGNED_DWORD_WIDENING_MUL: begin
        for (int h = 0; h < 2; h++) begin
          p64 = 64'($signed(a[32*h +: 32]) * $signed(b[32*h +: 32]));
          res[64*h +: 64] = p64;
        end
      end
      psalu_pkg::OP_BYTE_ABS_DIFF_SUM: begin
        for (int h = 0; h < 2; h++) begin
          sad = '0;
          for (int i = 0; i < 8; i++) begin
            d8 = (a[64*h+8*i +: 8] > b[64*h+8*i +: 8]) ?
                 a[64*h+8*i +: 8] - b[64*h+8*i +: 8] : b[64*h+8*i +: 8] - a[64*h+8*i +: 8];
            sad = sad + {8'h00, d8};
          end
          res[64*h +: 16] = sad;
        end
      end
      psalu_pkg::OP_MULTI_ABS_DIFF_SUM: begin
        for (int i = 0; i < 8; i++) begin
          res[16*i +: 16] = msad[i];
        end
      end
      psalu_pkg::OP_BYTE_ROUND_AVERAGE: begin
        for (int i = 0; i < 16; i++) begin
          s9 = {1'b0, a[8*i +: 8]} + {1'b0, b[8*i +: 8]} + 9'h001;
          res[8*i +: 8] = s9[8:1];
        end
      end
      psalu_pkg::OP_WORD_ROUND_AVERAGE: begin
        for (int i = 0; i < 8; i++) begin
          s17 = {1'b0, a[16*i +: 16]} + {1'b0, b[16*i +: 16]} + 17'h00001;
          res[16*i +: 16] = s17[16:1];
        end
      end
      psalu_pkg::OP_WORD_MUL_ADD: begin
        for (int i = 0; i < 4; i++) begin
          p32 = 32'($signed(a[32*i +: 16]) * $signed(b[32*i +: 16]));
          q32 = 32'($signed(a[32*i+16 +: 16]) * $signed(b[32*i+16 +: 16]));
          res[32*i +: 32] = p32 + q32;
        end
      end
      psalu_pkg::OP_QUAD_LANE_ADD: begin
        for (int h = 0; h < 2; h++) begin
          res[64*h +: 64] = a[64*h +: 64] + b[64*h +: 64];
        end
      end
      psalu_pkg::OP_QUAD_LANE_SUB: begin
        for (int h = 0; h < 2; h++) begin
          res[64*h +: 64] = a[64*h +: 64] - b[64*h +: 64];
        end
      end
      psalu_pkg::OP_REGISTER_BYTE_SHIFT_LEFT: begin
        if (req.imm <= psalu_pkg::IMM_W'(psalu_pkg::SHIFT_MAX)) begin
          sh = {128'h0, a} << {req.imm, 3'h0};
          res = sh[127:0];
        end
      end
      psalu_pkg::OP_REGISTER_BYTE_SHIFT_RIGHT: begin
        if (req.imm <= psalu_pkg::IMM_W'(psalu_pkg::SHIFT_MAX)) begin
          sh = {128'h0, a} >> {req.imm, 3'h0};
          res = sh[127:0];
        end
      end
      default: res = '0;
    endcase
    // narrow form leaves the upper half cleared
    if (!req.wide) begin
      res[127:64] = 64'h0;
    end
  end

  // ****************************************
  // result register
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.valid = req_valid;
    if (req_valid) begin
      next_state.rsp.data_write = (req.op != psalu_pkg::OP_VECTOR_TEST);
      next_state.rsp.flags_write = (req.op == psalu_pkg::OP_VECTOR_TEST);
      if (req.op == psalu_pkg::OP_VECTOR_TEST) begin
        next_state.rsp.data = state.rsp.data;
        next_state.rsp.zero_flag = ((a & b) == '0);
        next_state.rsp.carry_flag = ((~a & b) == '0);
      end else begin
        next_state.rsp.data = res;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign rsp_valid = state.valid;
  assign rsp = state.rsp;
endmodule // psalu_core
`default_nettype wire

// ==== include/psalu_pkg.sv ====
// package: opcodes, widths and carriers for the packed simd integer alu
package psalu_pkg;
  localparam int VEC_W = 128;
  localparam int HALF_W = 64;
  localparam int SHIFT_MAX = 15;
  localparam int IMM_W = 8;

  typedef enum logic [4:0] {
    OP_SIGNED_WORD_MAX,
    OP_SIGNED_WORD_MIN,
    OP_UNSIGNED_BYTE_MAX,
    OP_UNSIGNED_BYTE_MIN,
    OP_SIGNED_BYTE_MAX,
    OP_SIGNED_BYTE_MIN,
    OP_UNSIGNED_WORD_MAX,
    OP_UNSIGNED_WORD_MIN,
    OP_SIGNED_DWORD_MAX,
    OP_SIGNED_DWORD_MIN,
    OP_UNSIGNED_DWORD_MAX,
    OP_UNSIGNED_DWORD_MIN,
    OP_UNSIGNED_WORD_MUL_HIGH,
    OP_SIGNED_WORD_MUL_HIGH,
    OP_WORD_MUL_LOW,
    OP_UNSIGNED_DWORD_WIDENING_MUL,
    OP_DWORD_MUL_LOW,
    OP_SIGNED_DWORD_WIDENING_MUL,
    OP_BYTE_ABS_DIFF_SUM,
    OP_MULTI_ABS_DIFF_SUM,
    OP_BYTE_ROUND_AVERAGE,
    OP_WORD_ROUND_AVERAGE,
    OP_WORD_MUL_ADD,
    OP_QUAD_LANE_ADD,
    OP_QUAD_LANE_SUB,
    OP_REGISTER_BYTE_SHIFT_LEFT,
    OP_REGISTER_BYTE_SHIFT_RIGHT,
    OP_VECTOR_TEST
  } psalu_op_t;

  typedef struct packed {
    psalu_op_t op;
    logic wide;
    logic [IMM_W-1:0] imm;
    logic [VEC_W-1:0] dst_val;
    logic [VEC_W-1:0] src_val;
  } psalu_req_t;

  typedef struct packed {
    logic [VEC_W-1:0] data;
    logic data_write;
    logic flags_write;
    logic zero_flag;
    logic carry_flag;
  } psalu_rsp_t;
endpackage

// ==== logic/psalu_sad4.sv ====
// sum of absolute differences over four unsigned byte pairs
`timescale 1ns/1ps
`default_nettype none
module psalu_sad4 (
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [15:0] sum
);
  always_comb begin
    logic [7:0] d;
    d = 8'h00;
    sum = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      d = (a[8*i +: 8] > b[8*i +: 8]) ? a[8*i +: 8] - b[8*i +: 8] : b[8*i +: 8] - a[8*i +: 8];
      sum = sum + {8'h00, d};
    end
  end
endmodule // psalu_sad4
`default_nettype wire

// ==== verification/psalu_issue_model.sv ====
// issue-side model: presents one request per call to the alu core
`timescale 1ns/1ps
`default_nettype none
module psalu_issue_model (
  input wire logic clk_sys,
  output logic req_valid,
  output psalu_pkg::psalu_req_t req
);
  initial begin
    req_valid = 1'b0;
    req = '0;
  end
  // destination goes first, register or loaded value second
  task automatic send(input psalu_pkg::psalu_req_t r);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= r;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // released operands must not keep their last value
    req <= ~r;
  endtask
endmodule // psalu_issue_model
`default_nettype wire

// ==== verification/psalu_core_checker.sv ====
// concurrent checks on the ports of the alu core
`timescale 1ns/1ps
`default_nettype none
module psalu_core_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire psalu_pkg::psalu_req_t req,
  input wire logic rsp_valid,
  input wire psalu_pkg::psalu_rsp_t rsp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  psalu_pkg::psalu_req_t q;
  logic go;
  logic signed [15:0] dw, sw;
  logic signed [31:0] pm;
  logic [7:0] db, sb;
  logic [8:0] ab;
  assign go = clk_en && req_valid;
  assign dw = q.dst_val[15:0];
  assign sw = q.src_val[15:0];
  assign pm = dw * sw;
  assign db = q.dst_val[7:0];
  assign sb = q.src_val[7:0];
  assign ab = {1'b0, db} + {1'b0, sb} + 9'h001;
  // copy of the request taken, for judging its answer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else if (go) begin
      q <= req;
    end
  end
  // ****************
  // assertions
  // ****************
  property p_smax; go && req.op == psalu_pkg::OP_SIGNED_WORD_MAX |=>
    $signed(rsp.data[15:0]) == (dw > sw ? dw : sw); endproperty
  a_smax: assert property (p_smax) else $error("word max wrong");
  property p_umin; go && req.op == psalu_pkg::OP_UNSIGNED_BYTE_MIN |=>
    rsp.data[7:0] == (db < sb ? db : sb); endproperty
  a_umin: assert property (p_umin) else $error("byte min wrong");
  property p_mulh; go && req.op == psalu_pkg::OP_SIGNED_WORD_MUL_HIGH |=>
    rsp.data[15:0] == pm[31:16]; endproperty
  a_mulh: assert property (p_mulh) else $error("mul high wrong");
  property p_sad; go && req.op == psalu_pkg::OP_BYTE_ABS_DIFF_SUM |=>
    rsp.data[63:16] == 48'h0; endproperty
  a_sad: assert property (p_sad) else $error("sad upper words set");
  property p_avg; go && req.op == psalu_pkg::OP_BYTE_ROUND_AVERAGE |=>
    rsp.data[7:0] == ab[8:1]; endproperty
  a_avg: assert property (p_avg) else $error("average wrong");
  property p_qadd; go && req.op == psalu_pkg::OP_QUAD_LANE_ADD |=>
    rsp_valid && rsp.data[63:0] == q.dst_val[63:0] + q.src_val[63:0]; endproperty
  a_qadd: assert property (p_qadd) else $error("quad add wrong");
  property p_shz; go && req.op == psalu_pkg::OP_REGISTER_BYTE_SHIFT_LEFT
    && req.imm > 8'h0F |=> rsp.data == '0; endproperty
  a_shz: assert property (p_shz) else $error("long shift not zero");
  property p_test; go && req.op == psalu_pkg::OP_VECTOR_TEST |=> rsp.flags_write
    && !rsp.data_write && rsp.zero_flag == ((q.dst_val & q.src_val) == '0); endproperty
  a_test: assert property (p_test) else $error("test flags wrong");
endmodule // psalu_core_checker
bind psalu_core psalu_core_checker psalu_core_checker_i (.clk_sys(clk_sys), .reset_n(reset_n),
  .clk_en(clk_en), .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
`default_nettype wire

// ==== verification/psalu_core_tb_top.sv ====
// self-checking testbench for the alu core
`timescale 1ns/1ps
`default_nettype none
module psalu_core_tb_top;
  logic clk_sys, reset_n, clk_en, req_valid, rsp_valid;
  psalu_pkg::psalu_req_t req;
  psalu_pkg::psalu_rsp_t rsp;
  int n_mismatch = 0;
  int num_checks = 0;
  psalu_core psalu_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  psalu_issue_model psalu_issue_model_i (.clk_sys(clk_sys), .req_valid(req_valid), .req(req));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [132:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic run(input psalu_pkg::psalu_op_t op, input logic [127:0] d, s, e,
      input logic w = 1'b1, input logic [7:0] im = 8'h00);
    psalu_issue_model_i.send('{op, w, im, d, s});
    #1;
    chk({2'b00, rsp_valid, rsp.data_write, rsp.flags_write, rsp.data}, {2'b00, 3'b110, e});
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_minmax();
    logic [127:0] s;
    s = {8{16'h0001}};
    run(psalu_pkg::OP_SIGNED_WORD_MAX, '1, s, s);
    run(psalu_pkg::OP_SIGNED_WORD_MIN, '1, s, {64'h0, {64{1'b1}}}, 1'b0);
    run(psalu_pkg::OP_UNSIGNED_BYTE_MAX, '1, s, '1);
    run(psalu_pkg::OP_UNSIGNED_BYTE_MIN, '1, s, s);
    run(psalu_pkg::OP_SIGNED_BYTE_MAX, '1, s, s);
    run(psalu_pkg::OP_SIGNED_BYTE_MIN, '1, s, '1);
    run(psalu_pkg::OP_UNSIGNED_WORD_MAX, '1, s, '1);
    run(psalu_pkg::OP_UNSIGNED_WORD_MIN, '1, s, s);
    run(psalu_pkg::OP_SIGNED_DWORD_MAX, '1, s, s);
    run(psalu_pkg::OP_SIGNED_DWORD_MIN, '1, s, '1);
    run(psalu_pkg::OP_UNSIGNED_DWORD_MAX, '1, s, '1);
    run(psalu_pkg::OP_UNSIGNED_DWORD_MIN, '1, s, s);
  endtask
  task automatic t_mul();
    logic [127:0] d, s;
    d = {8{16'h8000}};
    s = {8{16'h0002}};
    run(psalu_pkg::OP_SIGNED_WORD_MUL_HIGH, d, s, '1);
    run(psalu_pkg::OP_UNSIGNED_WORD_MUL_HIGH, d, s, {8{16'h0001}});
    run(psalu_pkg::OP_WORD_MUL_LOW, d, s, '0);
    run(psalu_pkg::OP_UNSIGNED_DWORD_WIDENING_MUL, d, s, {2{64'h0001000200010000}});
    run(psalu_pkg::OP_DWORD_MUL_LOW, d, s, {4{32'h00010000}});
    run(psalu_pkg::OP_SIGNED_DWORD_WIDENING_MUL, d, s, {2{64'hFFFF000000010000}});
    run(psalu_pkg::OP_WORD_MUL_ADD, d, s, {4{32'hFFFE0000}});
    // distinct values in dwords 0 to 2, so the chosen pairs show
    d = 128'h00000009_00000003_00000009_00000002;
    s = 128'h00000009_00000005_00000009_00000007;
    run(psalu_pkg::OP_UNSIGNED_DWORD_WIDENING_MUL, d, s, {64'hF, 64'hE});
    run(psalu_pkg::OP_SIGNED_DWORD_WIDENING_MUL, d, s, {64'h51, 64'hE});
  endtask
  task automatic t_sum();
    logic [127:0] d, e;
    d = 128'h0F0E0D0C0B0A09080706050403020100;
    e = 128'h0022001E001A00160012000E000A0006;
    run(psalu_pkg::OP_MULTI_ABS_DIFF_SUM, d, '0, e);
    run(psalu_pkg::OP_BYTE_ABS_DIFF_SUM, '1, '0, {2{64'h07F8}});
    run(psalu_pkg::OP_MULTI_ABS_DIFF_SUM, '1, '0, {8{16'h03FC}});
    run(psalu_pkg::OP_BYTE_ROUND_AVERAGE, '1, '0, {16{8'h80}});
    run(psalu_pkg::OP_WORD_ROUND_AVERAGE, '1, '0, {8{16'h8000}});
    run(psalu_pkg::OP_QUAD_LANE_ADD, '1, {2{64'h2}}, {2{64'h1}});
    run(psalu_pkg::OP_QUAD_LANE_SUB, {2{64'h1}}, {2{64'h2}}, '1);
  endtask
  task automatic t_shift();
    logic [127:0] d;
    d = 128'h00112233445566778899AABBCCDDEEFF;
    for (int i = 0; i < 18; i++) begin
      run(psalu_pkg::OP_REGISTER_BYTE_SHIFT_LEFT, d, '1, d << (8 * i), 1'b1, 8'(i));
      run(psalu_pkg::OP_REGISTER_BYTE_SHIFT_RIGHT, d, '1, d >> (8 * i), 1'b1, 8'(i));
    end
  endtask
  task automatic t_freeze();
    run(psalu_pkg::OP_QUAD_LANE_ADD, '0, {2{64'h5}}, {2{64'h5}});
    @(posedge clk_sys);
    clk_en <= 1'b0;
    // request while frozen must leave the answer untouched
    psalu_issue_model_i.send('{psalu_pkg::OP_QUAD_LANE_SUB, 1'b1, 8'h00, '0, '1});
    #1;
    chk({5'h00, rsp_valid, rsp.data}, {5'h00, 1'b0, {2{64'h5}}});
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask
  task automatic t_test(input logic [127:0] d, s, input logic [1:0] zc);
    logic [4:0] f;
    // known nonzero data first, so a stray write shows
    run(psalu_pkg::OP_REGISTER_BYTE_SHIFT_LEFT, d, s, d);
    psalu_issue_model_i.send('{psalu_pkg::OP_VECTOR_TEST, 1'b1, 8'h00, d, s});
    #1;
    f = {rsp_valid, rsp.flags_write, rsp.data_write, rsp.zero_flag, rsp.carry_flag};
    chk({f, rsp.data}, {3'b110, zc, d});
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_minmax();
    t_mul();
    t_sum();
    t_shift();
    t_freeze();
    t_test({16{8'hF0}}, {16{8'h0F}}, 2'b10);
    t_test('1, {16{8'h01}}, 2'b01);
    stop_test();
  end
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule // psalu_core_tb_top
`default_nettype wire
